// >>> pscd_top.sv
// pscd_top: five post-scale dividers, global clock selection and
// reference switch, with an apb register slave
// assumes: core select and enable come from logic on clk; reference and
// dedicated clock pins are asynchronous and are synchronised here
module pscd_top #(
    parameter int unsigned          ROUTE_A      = 0,     // counter routed as candidate 2
    parameter int unsigned          ROUTE_B      = 1,     // counter routed as candidate 3
    parameter logic                 MANUAL_SWITCH = 1'b0, // reference switch from logic
    parameter logic                 CFG_REF_SEL   = 1'b0  // reference choice from configuration
) (
    input  wire logic                         clk,          // oscillator clock, 40 MHz
    input  wire logic                         rst_n,        // async reset, active low
    // apb slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [7:0]                   paddr,
    input  wire logic [31:0]                  pwdata,
    output logic [31:0]                       prdata,
    output logic                              pready,
    output logic                              pslverr,
    // core logic controls
    input  wire logic [1:0]                   clk_select,   // dynamic source select
    input  wire logic                         glob_enable,  // global output enable
    input  wire logic                         ref_switch,   // manual reference switch
    // asynchronous clock pins
    input  wire logic                         pin_clk_a,    // dedicated clock pin, candidate 0
    input  wire logic                         pin_clk_b,    // dedicated clock pin, candidate 1
    input  wire logic                         ref_clk_a,    // reference candidate 0
    input  wire logic                         ref_clk_b,    // reference candidate 1
    // outputs
    output logic [pscd_pkg::N_CNT-1:0]        div_clk,      // divided levels c4..c0
    output logic [pscd_pkg::N_CNT-1:0]        div_half,     // mid-cycle fall flags
    output logic                              global_clock_network, // selected and gated clock
    output logic                              glob_half,    // mid-cycle fall of that clock
    output logic                              ref_clk_out   // loop input clock
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // only two of the five counters may be routed
    if (ROUTE_A >= pscd_pkg::N_CNT || ROUTE_B >= pscd_pkg::N_CNT || ROUTE_A == ROUTE_B) begin : g_bad_route
        $error("route indices must be distinct and below five");
    end

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [pscd_pkg::CNT_W-1:0]   cnt_high  [pscd_pkg::N_CNT];   // high counts
    logic [pscd_pkg::CNT_W-1:0]   cnt_low   [pscd_pkg::N_CNT];   // low counts
    logic [pscd_pkg::N_CNT-1:0]   cnt_bypass;                    // bypass bits
    logic [pscd_pkg::N_CNT-1:0]   cnt_odd;                       // odd divide bits
    logic [7:0]                   cnt_phase [pscd_pkg::N_CNT];   // phase settings
    logic                         refsw_dyn;                     // software reference choice

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire                          setup    = psel && !penable && !pready;
    // a write lands only at the edge that completes the transfer
    wire                          do_write = psel && penable && pready && pwrite;
    wire [2:0]                    word_idx = paddr[4:2];         // counter index
    wire                          aligned  = (paddr[1:0] == 2'b00);
    wire                          hit_div  = aligned && (paddr[7:5] == 3'b000) && (word_idx < 3'd5);
    wire                          hit_phs  = aligned && (paddr[7:5] == 3'b001) && (word_idx < 3'd5);
    wire                          hit_ref  = (paddr == pscd_pkg::OFS_REFSW);
    wire                          hit_stat = (paddr == pscd_pkg::OFS_STAT);
    wire                          mapped   = hit_div || hit_phs || hit_ref || hit_stat;

    // ------------------------------------------------------------
    // synchronisers for the asynchronous pins; only the second stage
    // is read anywhere
    // ------------------------------------------------------------
    logic [3:0]                   sync_1;                        // first stage
    logic [3:0]                   sync_2;                        // second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_1 <= 4'h0;
            sync_2 <= 4'h0;
        end else begin
            sync_1 <= {ref_clk_b, ref_clk_a, pin_clk_b, pin_clk_a};
            sync_2 <= sync_1;
        end
    end

    // ------------------------------------------------------------
    // per counter: storage writes and the divider itself
    // ------------------------------------------------------------
    logic [pscd_pkg::N_CNT-1:0]   cnt_level;                     // divider outputs
    logic [pscd_pkg::N_CNT-1:0]   cnt_halfc;                     // divider half flags

    for (genvar i = 0; i < pscd_pkg::N_CNT; i++) begin : g_cnt
        wire wr_div = do_write && hit_div && (word_idx == 3'(i));
        wire wr_phs = do_write && hit_phs && (word_idx == 3'(i));

        // divider word: high and low counts loaded together in one write, one word per counter
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                cnt_high[i]   <= pscd_pkg::RST_HIGH;
                cnt_low[i]    <= pscd_pkg::RST_LOW;
                cnt_bypass[i] <= 1'b0;
                cnt_odd[i]    <= 1'b0;
            end else if (wr_div) begin
                cnt_high[i]   <= pwdata[pscd_pkg::F_HIGH +: pscd_pkg::CNT_W];
                cnt_low[i]    <= pwdata[pscd_pkg::F_LOW  +: pscd_pkg::CNT_W];
                cnt_bypass[i] <= pwdata[pscd_pkg::F_BYPASS];
                cnt_odd[i]    <= pwdata[pscd_pkg::F_ODD];
            end
        end

        // phase word changes only through its own address; a divider write
        // leaves it alone, so software need not rewrite it afterwards
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                cnt_phase[i] <= pscd_pkg::RST_PHASE;
            end else if (wr_phs) begin
                cnt_phase[i] <= pwdata[7:0];
            end
        end

        // one of five independent counters
        pscd_post_counter u_cnt (
            .clk        (clk),
            .rst_n      (rst_n),
            .cfg_high   (cnt_high[i]),
            .cfg_low    (cnt_low[i]),
            .cfg_bypass (cnt_bypass[i]),
            .cfg_odd    (cnt_odd[i]),
            .div_out    (cnt_level[i]),
            .div_half   (cnt_halfc[i])
        );
    end

    assign div_clk  = cnt_level;
    assign div_half = cnt_halfc;

    // ------------------------------------------------------------
    // reference switch: software copy used only in manual mode
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            refsw_dyn <= 1'b0;
        end else if (do_write && hit_ref) begin
            refsw_dyn <= pwdata[0];
        end
    end

    // configuration fixes the choice unless manual switchover is built in;
    // then core pin or register bit may flip it
    wire                          ref_pick = MANUAL_SWITCH ? (ref_switch ^ refsw_dyn) : CFG_REF_SEL;
    wire                          ref_lvl  = ref_pick ? sync_2[3] : sync_2[2];

    // ------------------------------------------------------------
    // global clock selection
    // ------------------------------------------------------------
    // routes are parameters: no register can reach them
    wire [pscd_pkg::N_CAND-1:0]   cand_lvl  = {cnt_level[ROUTE_B], cnt_level[ROUTE_A], sync_2[1], sync_2[0]};
    wire [pscd_pkg::N_CAND-1:0]   cand_half = {cnt_halfc[ROUTE_B], cnt_halfc[ROUTE_A], 2'b00};
    // two of four candidates are loop counters
    // core select chooses among candidates every cycle
    wire                          sel_lvl   = cand_lvl[clk_select];
    wire                          sel_half  = cand_half[clk_select];

    // registered, gated output; disabled output sits low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            global_clock_network <= 1'b0;
            glob_half            <= 1'b0;
            ref_clk_out          <= 1'b0;
        end else begin
            global_clock_network <= glob_enable && sel_lvl;
            glob_half            <= glob_enable && sel_half;
            ref_clk_out          <= ref_lvl;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [31:0]                  rd_word;                       // word addressed now
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_div) begin
            rd_word[pscd_pkg::F_HIGH +: pscd_pkg::CNT_W] = cnt_high[word_idx];
            rd_word[pscd_pkg::F_LOW  +: pscd_pkg::CNT_W] = cnt_low[word_idx];
            rd_word[pscd_pkg::F_BYPASS]                  = cnt_bypass[word_idx];
            rd_word[pscd_pkg::F_ODD]                     = cnt_odd[word_idx];
        end else if (hit_phs) begin
            rd_word[7:0] = cnt_phase[word_idx];
        end else if (hit_ref) begin
            rd_word[0] = refsw_dyn;
        end else if (hit_stat) begin
            rd_word[pscd_pkg::F_ST_DIV +: pscd_pkg::N_CNT] = cnt_level;
            rd_word[pscd_pkg::F_ST_SEL +: 2]               = clk_select;
            rd_word[pscd_pkg::F_ST_EN]                     = glob_enable;
            rd_word[pscd_pkg::F_ST_GLOB]                   = global_clock_network;
            rd_word[pscd_pkg::F_ST_REF]                    = ref_pick;
        end
    end

    // ------------------------------------------------------------
    // apb answer: one access cycle, ready raised during it; unmapped
    // addresses answer with an error and read zero
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (setup) begin
            pready  <= 1'b1;
            pslverr <= !mapped;
            prdata  <= pwrite ? 32'h0000_0000 : rd_word;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule

// >>> pscd_pkg.sv
// pscd_pkg: constants shared by the post-scale divider and clock select block
// assumes: one 40 MHz clock; apb slave with 32-bit data, one word per register
//
// What this block does
// - each counter: loadable 8-bit high, low counts
// - bypass bit 1 passes clock, divide one
// - bypass 0: period is high plus low
// - duty equals high time over whole period
// - odd bit clear: falls on rising edge
// - odd bit set: falls on falling edge
// - odd bit: high minus half, low plus half
// - frequency writes never alter phase setting
// - five counter outputs, indexed four to zero
// - only two counters reach clock select
// - select takes one of four candidates
// - core drives 2-bit dynamic source select
// - static selects fixed at configuration only
// - core enables or disables global output
// - reference switch: configuration or manual logic
package pscd_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int unsigned N_CNT     = 5;              // counter outputs c4..c0
    localparam int unsigned CNT_W     = 8;              // high and low count width
    localparam int unsigned N_CAND    = 4;              // candidates into the selector
    localparam int unsigned CLK_HZ    = 40_000_000;     // system clock rate

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_DIV0   = 8'h00;          // divider word of counter 0, +4 per counter
    localparam logic [7:0] OFS_PHS0   = 8'h20;          // phase word of counter 0, +4 per counter
    localparam logic [7:0] OFS_REFSW  = 8'h40;          // reference switch control
    localparam logic [7:0] OFS_STAT   = 8'h44;          // live status, read only

    // ------------------------------------------------------------
    // divider word fields
    // ------------------------------------------------------------
    localparam int unsigned F_HIGH    = 0;              // high count [7:0]
    localparam int unsigned F_LOW     = 8;              // low count [15:8]
    localparam int unsigned F_BYPASS  = 16;             // counter bypass
    localparam int unsigned F_ODD     = 17;             // odd divide half cycle

    // ------------------------------------------------------------
    // status word fields
    // ------------------------------------------------------------
    localparam int unsigned F_ST_DIV  = 0;              // counter levels [4:0]
    localparam int unsigned F_ST_SEL  = 8;              // current source select [9:8]
    localparam int unsigned F_ST_EN   = 10;             // global enable
    localparam int unsigned F_ST_GLOB = 11;             // global output level
    localparam int unsigned F_ST_REF  = 12;             // reference chosen

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_HIGH   = 8'h01;          // divide by two, 50 % duty
    localparam logic [7:0] RST_LOW    = 8'h01;
    localparam logic [7:0] RST_PHASE  = 8'h00;

    // counter phase
    typedef enum logic {PSCD_PH_HIGH, PSCD_PH_LOW} pscd_phase_e;

endpackage

// >>> pscd_post_counter.sv
// pscd_post_counter: one post-scale counter producing a divided clock level
// assumes: settings come from registers on the same clock; the divided
// output is expressed in whole clock cycles plus a half-cycle flag
module pscd_post_counter (
    input  wire logic                         clk,        // oscillator clock
    input  wire logic                         rst_n,      // async reset, active low
    input  wire logic [pscd_pkg::CNT_W-1:0]   cfg_high,   // high time count
    input  wire logic [pscd_pkg::CNT_W-1:0]   cfg_low,    // low time count
    input  wire logic                         cfg_bypass, // pass clock straight
    input  wire logic                         cfg_odd,    // fall on falling edge
    output logic                              div_out,    // divided level
    output logic                              div_half    // high only first half of cycle
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    pscd_pkg::pscd_phase_e                phase;          // high or low part of period
    pscd_pkg::pscd_phase_e                next_phase;
    logic [pscd_pkg::CNT_W:0]             cnt;            // cycles left in this part
    logic [pscd_pkg::CNT_W:0]             next_cnt;
    logic [pscd_pkg::CNT_W:0]             high_len;       // zero count stands for 256
    logic [pscd_pkg::CNT_W:0]             low_len;
    logic                                 last;           // final cycle of this part

    // a zero count would wrap the counter to 511, so it means the full 256 cycles
    assign high_len   = (cfg_high == '0) ? 9'h100 : {1'b0, cfg_high};
    assign low_len    = (cfg_low  == '0) ? 9'h100 : {1'b0, cfg_low};
    assign last       = (cnt == 9'h001);
    // period is high plus low; duty follows the two counts
    assign next_phase = last ? ((phase == pscd_pkg::PSCD_PH_HIGH) ? pscd_pkg::PSCD_PH_LOW
                                                                : pscd_pkg::PSCD_PH_HIGH)
                             : phase;
    assign next_cnt   = !last ? cnt - 9'h001
                      : (phase == pscd_pkg::PSCD_PH_HIGH) ? low_len : high_len;

    // ------------------------------------------------------------
    // counting; new high and low counts are read only at part boundaries so a
    // reload mid-period never produces a runt pulse
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= pscd_pkg::PSCD_PH_HIGH;
            cnt   <= 9'h001;
        end else begin
            phase <= next_phase;
            cnt   <= next_cnt;
        end
    end

    // ------------------------------------------------------------
    // output levels, registered so that they never glitch
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_out  <= 1'b0;
            div_half <= 1'b0;
        end else if (cfg_bypass) begin
            // each cycle high then low: the clock itself
            div_out  <= 1'b1;
            div_half <= 1'b1;
        end else begin
            // high for the high part; rising-edge fall when odd clear
            div_out  <= (next_phase == pscd_pkg::PSCD_PH_HIGH);
            // last high cycle falls mid-cycle: high minus half, low plus half
            div_half <= cfg_odd && (next_phase == pscd_pkg::PSCD_PH_HIGH) && (next_cnt == 9'h001);
        end
    end

endmodule

// >>> pscd_checker.sv
// pscd_checker: concurrent checks on the ports of pscd_top
// assumes: one clock, async active-low reset; bound into every pscd_top
module pscd_checker #(
    parameter int unsigned ROUTE_A       = 0,
    parameter logic        MANUAL_SWITCH = 1'b0,
    parameter logic        CFG_REF_SEL   = 1'b0
) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic [1:0] clk_select,
    input wire logic       glob_enable,
    input wire logic       ref_clk_a,
    input wire logic       ref_clk_b,
    input wire logic [4:0] div_clk,
    input wire logic [4:0] div_half,
    input wire logic       global_clock_network,
    input wire logic       ref_clk_out
);
    // ----------------------------------------
    // all checks share the one clock domain
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // holes in the map: unaligned, between the word groups, above status
    wire hole = (paddr[1:0] != 2'b00) || (paddr > 8'h44) || (paddr > 8'h10 && paddr < 8'h20)
                || (paddr > 8'h30 && paddr < 8'h40);

    a_apb_answer_one: assert property (psel && !penable && !pready |=> pready) else $error("no ready after setup");
    a_ready_one_pulse: assert property (pready |=> !pready) else $error("ready held too long");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_err_on_hole: assert property (pready && hole |-> pslverr) else $error("hole not refused");
    a_glob_gated_off: assert property (!$past(glob_enable) |-> !global_clock_network)
        else $error("global clock ran while disabled");
    // a three-cycle window hides a one-edge offset between counter and selector
    a_glob_picks_ctr: assert property ((glob_enable && clk_select == 2'd2 && $stable(div_clk[ROUTE_A]))[*3]
        |-> global_clock_network == div_clk[ROUTE_A]) else $error("selected counter not passed");
    a_half_only_high: assert property ((div_half & ~div_clk) == 5'h00)
        else $error("half flag while output low");
    a_ref_static_pick: assert property (!MANUAL_SWITCH && $past(rst_n, 3)
        |-> ref_clk_out == (CFG_REF_SEL ? $past(ref_clk_b, 3) : $past(ref_clk_a, 3))) else $error("reference pick wrong");
endmodule

bind pscd_top pscd_checker #(.ROUTE_A(ROUTE_A), .MANUAL_SWITCH(MANUAL_SWITCH), .CFG_REF_SEL(CFG_REF_SEL)) pscd_checker_inst (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .clk_select(clk_select), .glob_enable(glob_enable), .ref_clk_a(ref_clk_a), .ref_clk_b(ref_clk_b),
    .div_clk(div_clk), .div_half(div_half), .global_clock_network(global_clock_network), .ref_clk_out(ref_clk_out));

// >>> pscd_core_model.sv
// pscd_core_model: core logic and clock pins facing the selector
// assumes: bench asks for select and enable; pins derive from one tick counter
module pscd_core_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] want_sel,    // source asked for by the bench
    input  wire logic       want_en,     // enable asked for by the bench
    output logic [1:0]      clk_select,
    output logic            glob_enable,
    output logic            pin_clk_a,
    output logic            pin_clk_b,
    output logic            ref_clk_a,
    output logic            ref_clk_b
);
    logic [4:0] tick;                    // free count, its bits make the pin clocks
    // controls change only after an edge, like real core flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick        <= 5'h00;
            clk_select  <= 2'h0;
            glob_enable <= 1'b0;
        end else begin
            tick        <= tick + 5'h01;
            clk_select  <= want_sel;
            glob_enable <= want_en;
        end
    end
    assign pin_clk_a = tick[2];          // period 8 so a switch is easy to see
    assign pin_clk_b = tick[3];
    assign ref_clk_a = tick[1];
    assign ref_clk_b = tick[3];
endmodule

// >>> tb_top.sv
// tb_top: register and port level tests of pscd_top
// assumes: core model drives selector controls; apb master lives here
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, want_en = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [1:0]  want_sel = 2'h0, clk_select;
    logic [4:0]  div_clk, div_half;
    logic        pready, pslverr, er, glob_enable, pin_clk_a, pin_clk_b, ref_clk_a, ref_clk_b;
    logic        global_clock_network, glob_half, ref_clk_out;
    int          fails = 0, num_checks = 0, cyc = 0, n, hi, lo;
    wire  [12:0] obs = {ref_clk_out, glob_half, global_clock_network, div_half, div_clk}; // 10 global, 11 its half, 12 ref

    always #12.5 clk = ~clk;

    pscd_core_model pscd_core_model_inst (.clk(clk), .rst_n(rst_n), .want_sel(want_sel), .want_en(want_en),
        .clk_select(clk_select), .glob_enable(glob_enable), .pin_clk_a(pin_clk_a), .pin_clk_b(pin_clk_b),
        .ref_clk_a(ref_clk_a), .ref_clk_b(ref_clk_b));
    pscd_top pscd_top_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clk_select(clk_select), .glob_enable(glob_enable), .ref_switch(1'b0), .pin_clk_a(pin_clk_a),
        .pin_clk_b(pin_clk_b), .ref_clk_a(ref_clk_a), .ref_clk_b(ref_clk_b), .div_clk(div_clk),
        .div_half(div_half), .global_clock_network(global_clock_network), .glob_half(glob_half),
        .ref_clk_out(ref_clk_out));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one apb transfer; the request stands until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no limit here; if pready never comes, only the bench timeout ends this wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // high samples of one observed bit over a fixed span
    task automatic count(input int k, input int span);
        n = 0;
        repeat (span) begin
            @(posedge clk);
            if (obs[k] === 1'b1) n++;
        end
    endtask
    // lengths of one whole high run and the low run after it
    task automatic runs(input int k);
        int i;
        i = 0;
        while (obs[k] !== 1'b0 && i < 600) begin @(posedge clk); i++; end
        while (obs[k] !== 1'b1 && i < 600) begin @(posedge clk); i++; end
        hi = 0; lo = 0;
        while (obs[k] === 1'b1 && hi < 600) begin @(posedge clk); hi++; end
        while (obs[k] === 1'b0 && lo < 600) begin @(posedge clk); lo++; end
    endtask
    task automatic print_verdict;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // a hang counts against the run; the whole sequence needs far fewer cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin fails++; print_verdict; end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk); // counters open with one low cycle after release
        for (int k = 0; k < 5; k++) begin count(k, 20); check(n, 10); end
        apb(1'b1, 8'h24, 32'h0000_005a);
        apb(1'b1, 8'h04, 32'h0000_0203);
        apb(1'b0, 8'h04, 32'h0000_0000); check(rd, 32'h0000_0203);
        apb(1'b0, 8'h24, 32'h0000_0000); check(rd, 32'h0000_005a);
        apb(1'b1, 8'h24, 32'h0000_005a);
        apb(1'b1, 8'h08, 32'h0002_0102); // odd divide by three
        apb(1'b1, 8'h0c, 32'h0001_0505); // bypassed, counts ignored
        apb(1'b1, 8'h00, 32'h0000_0404);
        repeat (20) @(posedge clk);
        runs(1); check(hi, 3); check(lo, 2);
        count(6, 30); check(n, 0);
        count(7, 30); check(n, 10);
        runs(2); check(hi, 2); check(lo, 1);
        count(3, 20); check(n, 20);
        count(8, 20); check(n, 20);
        apb(1'b0, 8'h48, 32'h0000_0000); check(er, 1); check(rd, 0);
        want_sel <= 2'h2;
        count(10, 40); check(n, 0);
        want_en <= 1'b1;
        repeat (4) @(posedge clk); // let the enable reach the output before timing runs
        runs(10); check(hi, 4); check(lo, 4);
        want_sel <= 2'h3;
        repeat (4) @(posedge clk); // no run spliced from two sources
        runs(10); check(hi, 3); check(lo, 2);
        apb(1'b1, 8'h04, 32'h0002_0203);
        repeat (10) @(posedge clk);
        count(11, 25); check(n, 5);
        want_sel <= 2'h1;
        repeat (10) @(posedge clk);
        count(10, 64); check(n, 32);
        want_sel <= 2'h0;
        repeat (10) @(posedge clk);
        count(10, 64); check(n, 32);
        apb(1'b0, 8'h44, 32'h0000_0000); check(rd & 32'h0000_0700, 32'h0000_0400);
        apb(1'b1, 8'h40, 32'h0000_0001);
        apb(1'b0, 8'h40, 32'h0000_0000); check(rd, 32'h0000_0001);
        count(12, 40); check(n, 20);
        print_verdict;
    end
endmodule
